// ### hdl/ssie_regs.svh
// Register offsets, field positions and reset values of the status and interrupt enable block.
`ifndef SSIE_REGS_SVH
`define SSIE_REGS_SVH

`define SSIE_IRQ_ENABLE_OFS    12'h0DC
`define SSIE_IRQ_STATUS_OFS    12'h10C
`define SSIE_SEC_STATUS_OFS    12'h114
`define SSIE_ADDR_W            12

`define SSIE_ENABLE_RESET      32'h0000_0000
`define SSIE_STATUS_RESET      32'h0000_0000
`define SSIE_SEC_RESET         13'h0000

// Interrupt status / enable bit positions.
`define SSIE_BIT_AUDIO_FIFO    11
`define SSIE_BIT_VIDEO_FIFO    9
`define SSIE_BIT_COMBINED_CNT  2

// Secondary status field positions.
`define SSIE_SEC_VF2           12
`define SSIE_SEC_VF1           11
`define SSIE_SEC_AIN2          10
`define SSIE_SEC_AOUT2         9
`define SSIE_SEC_AIN1          8
`define SSIE_SEC_AOUT1         7
`define SSIE_SEC_VGATE         5
`define SSIE_SEC_LGATE         4
`define SSIE_SEC_CNT5          3
`define SSIE_SEC_CNT4          2
`define SSIE_SEC_CNT2          1
`define SSIE_SEC_CNT1          0

`endif

// ### hdl/ssie_pkg.sv
// Types shared by the status and interrupt enable block.
package ssie_pkg;
    typedef enum logic [1:0] {
        SSIE_APB_IDLE   = 2'b01,
        SSIE_APB_ACCESS = 2'b10
    } ssie_apb_state_type;
endpackage : ssie_pkg

// ### hdl/ssie_top.sv
// Secondary status, interrupt status and interrupt enable registers with APB access.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "ssie_regs.svh"

module ssie_top
    import ssie_pkg::*;
#(
    parameter int SRC_W = 32
) (
    // Clock and reset.
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Interrupt source pulses, one per interrupt status bit.
    input  wire logic [SRC_W-1:0]  irq_source,
    // FIFO error pulses.
    input  wire logic              video_fifo_two_err,
    input  wire logic              video_fifo_one_ovf,
    input  wire logic              audio_in_fifo_two_udf,
    input  wire logic              audio_out_fifo_two_ovf,
    input  wire logic              audio_in_fifo_one_udf,
    input  wire logic              audio_out_fifo_one_ovf,
    // Clear strobes from the DMA logic.
    input  wire logic              video_base_reload,
    input  wire logic              audio_in_two_restart,
    input  wire logic              audio_out_two_restart,
    input  wire logic              audio_in_one_restart,
    input  wire logic              audio_out_one_restart,
    // Scaler output gates, asynchronous to pclk.
    input  wire logic              vertical_gate_mon,
    input  wire logic              line_qualifier_mon,
    // Event counter threshold pulses.
    input  wire logic              counter_five_flag,
    input  wire logic              counter_four_flag,
    input  wire logic              counter_two_flag,
    input  wire logic              counter_one_flag,
    // Host interrupt request.
    output logic                   host_irq
);

    ssie_apb_state_type  apb_q;
    logic [31:0]         enable_q;
    logic [31:0]         status_q;
    logic                vf2_err_q;
    logic                vf1_ovf_q;
    logic                ain2_udf_q;
    logic                aout2_ovf_q;
    logic                ain1_udf_q;
    logic                aout1_ovf_q;
    logic                cnt5_q;
    logic                cnt4_q;
    logic                cnt2_q;
    logic                cnt1_q;
    logic                vgate_meta_q;
    logic                vgate_sync_q;
    logic                lgate_meta_q;
    logic                lgate_sync_q;
    logic [31:0]         rd_mux;
    logic                host_irq_q;
    logic [31:0]         prdata_q;
    logic                pslverr_q;

    logic                access;
    logic                wr_en;
    logic                rd_en;
    logic [11:0]         ofs;
    logic                hit_enable;
    logic                hit_status;
    logic                hit_sec;
    logic [31:0]         wmask;
    logic [31:0]         w1c;
    logic                clr_video;
    logic                clr_audio;
    logic                clr_count;
    logic [31:0]         set_vec;
    logic [31:0]         sec_view;

    // APB decode: every access completes in its first access cycle.
    assign ofs        = paddr[`SSIE_ADDR_W-1:0];
    assign access     = psel && penable;
    assign wr_en      = access && pwrite;
    assign rd_en      = access && !pwrite;
    assign hit_enable = (ofs == `SSIE_IRQ_ENABLE_OFS);
    assign hit_status = (ofs == `SSIE_IRQ_STATUS_OFS);
    assign hit_sec    = (ofs == `SSIE_SEC_STATUS_OFS);
    assign pready     = (apb_q == SSIE_APB_ACCESS);

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{pstrb[i]}};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_q <= SSIE_APB_IDLE;
        end else begin
            case (apb_q)
                SSIE_APB_IDLE: begin
                    if (psel && !penable) begin
                        apb_q <= SSIE_APB_ACCESS;
                    end
                end
                SSIE_APB_ACCESS: begin
                    apb_q <= SSIE_APB_IDLE;
                end
                default: begin
                    apb_q <= SSIE_APB_IDLE;
                end
            endcase
        end
    end

    // Write-one-to-clear vector for the interrupt status register.
    assign w1c       = (wr_en && pready && hit_status) ? (pwdata & wmask) : 32'h0000_0000;
    assign clr_video = w1c[`SSIE_BIT_VIDEO_FIFO];
    assign clr_audio = w1c[`SSIE_BIT_AUDIO_FIFO];
    assign clr_count = w1c[`SSIE_BIT_COMBINED_CNT];

    // Enable register, fully read/write with byte strobes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= `SSIE_ENABLE_RESET;
        end else if (wr_en && pready && hit_enable) begin
            enable_q <= (enable_q & ~wmask) | (pwdata & wmask);
        end
    end

    // Scaler gates are asynchronous, so each passes its own two-stage synchroniser.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vgate_meta_q <= 1'b0;
            vgate_sync_q <= 1'b0;
        end else begin
            vgate_meta_q <= vertical_gate_mon;
            vgate_sync_q <= vgate_meta_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lgate_meta_q <= 1'b0;
            lgate_sync_q <= 1'b0;
        end else begin
            lgate_meta_q <= line_qualifier_mon;
            lgate_sync_q <= lgate_meta_q;
        end
    end

    // Secondary status error flags: a set in the clearing cycle wins, so no event is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vf2_err_q <= 1'b0;
        end else if (video_fifo_two_err) begin
            vf2_err_q <= 1'b1;
        end else if (video_base_reload || clr_video) begin
            vf2_err_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vf1_ovf_q <= 1'b0;
        end else if (video_fifo_one_ovf) begin
            vf1_ovf_q <= 1'b1;
        end else if (video_base_reload || clr_video) begin
            vf1_ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ain2_udf_q <= 1'b0;
        end else if (audio_in_fifo_two_udf) begin
            ain2_udf_q <= 1'b1;
        end else if (audio_in_two_restart || clr_audio) begin
            ain2_udf_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aout2_ovf_q <= 1'b0;
        end else if (audio_out_fifo_two_ovf) begin
            aout2_ovf_q <= 1'b1;
        end else if (audio_out_two_restart || clr_audio) begin
            aout2_ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ain1_udf_q <= 1'b0;
        end else if (audio_in_fifo_one_udf) begin
            ain1_udf_q <= 1'b1;
        end else if (audio_in_one_restart || clr_audio) begin
            ain1_udf_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aout1_ovf_q <= 1'b0;
        end else if (audio_out_fifo_one_ovf) begin
            aout1_ovf_q <= 1'b1;
        end else if (audio_out_one_restart || clr_audio) begin
            aout1_ovf_q <= 1'b0;
        end
    end

    // Counter threshold flags are cleared only through the combined status bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt5_q <= 1'b0;
        end else if (counter_five_flag) begin
            cnt5_q <= 1'b1;
        end else if (clr_count) begin
            cnt5_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt4_q <= 1'b0;
        end else if (counter_four_flag) begin
            cnt4_q <= 1'b1;
        end else if (clr_count) begin
            cnt4_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt2_q <= 1'b0;
        end else if (counter_two_flag) begin
            cnt2_q <= 1'b1;
        end else if (clr_count) begin
            cnt2_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt1_q <= 1'b0;
        end else if (counter_one_flag) begin
            cnt1_q <= 1'b1;
        end else if (clr_count) begin
            cnt1_q <= 1'b0;
        end
    end

    // Secondary status as read: live gates, reserved and unlisted bits zero.
    always_comb begin
        sec_view = 32'h0000_0000;
        sec_view[`SSIE_SEC_VF2] = vf2_err_q;
        sec_view[`SSIE_SEC_VF1] = vf1_ovf_q;
        sec_view[`SSIE_SEC_AIN2] = ain2_udf_q;
        sec_view[`SSIE_SEC_AOUT2] = aout2_ovf_q;
        sec_view[`SSIE_SEC_AIN1] = ain1_udf_q;
        sec_view[`SSIE_SEC_AOUT1] = aout1_ovf_q;
        sec_view[`SSIE_SEC_VGATE] = vgate_sync_q;
        sec_view[`SSIE_SEC_LGATE] = lgate_sync_q;
        sec_view[`SSIE_SEC_CNT5] = cnt5_q;
        sec_view[`SSIE_SEC_CNT4] = cnt4_q;
        sec_view[`SSIE_SEC_CNT2] = cnt2_q;
        sec_view[`SSIE_SEC_CNT1] = cnt1_q;
    end

    // Interrupt status sources; the grouped FIFO and counter bits are also set by the pulses that set their flags.
    always_comb begin
        set_vec = irq_source;
        set_vec[`SSIE_BIT_VIDEO_FIFO] = irq_source[`SSIE_BIT_VIDEO_FIFO] | video_fifo_two_err | video_fifo_one_ovf;
        set_vec[`SSIE_BIT_AUDIO_FIFO] = irq_source[`SSIE_BIT_AUDIO_FIFO] | audio_in_fifo_two_udf
                                      | audio_out_fifo_two_ovf | audio_in_fifo_one_udf | audio_out_fifo_one_ovf;
        set_vec[`SSIE_BIT_COMBINED_CNT] = irq_source[`SSIE_BIT_COMBINED_CNT] | counter_five_flag
                                        | counter_four_flag | counter_two_flag | counter_one_flag;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= `SSIE_STATUS_RESET;
        end else begin
            status_q <= set_vec | (status_q & ~w1c);
        end
    end

    // Interrupt request follows any enabled pending source one cycle later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_irq_q <= 1'b0;
        end else begin
            host_irq_q <= |(status_q & enable_q);
        end
    end
    assign host_irq = host_irq_q;

    // Read selection; writes and unmapped offsets return zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (!pwrite && hit_enable) begin
            rd_mux = enable_q;
        end else if (!pwrite && hit_status) begin
            rd_mux = status_q;
        end else if (!pwrite && hit_sec) begin
            rd_mux = sec_view;
        end
    end

    // Read data is registered in the setup cycle, so the access cycle can answer at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_q <= rd_mux;
        end
    end

    // Error response is decided in the setup cycle as well.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_q <= !(hit_enable || hit_status || hit_sec) || (pwrite && hit_sec);
        end
    end
    assign prdata  = (rd_en && pready) ? prdata_q : 32'h0000_0000;
    assign pslverr = pready ? pslverr_q : 1'b0;

endmodule : ssie_top

// ### dv/ssie_top_chk.sv
// Checker of the APB answer and the host interrupt of the status block.
`timescale 1ns/1ps
`include "ssie_regs.svh"
module ssie_chk (
    // Clock and reset.
    input wire logic        pclk,
    input wire logic        presetn,
    // APB.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Interrupts.
    input wire logic [31:0] irq_source,
    input wire logic        host_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [11:0] ofs = paddr[11:0];
    wire mapped = ofs == `SSIE_IRQ_ENABLE_OFS || ofs == `SSIE_IRQ_STATUS_OFS || ofs == `SSIE_SEC_STATUS_OFS;
    wire en_wr = pready && pwrite && ofs == `SSIE_IRQ_ENABLE_OFS && pstrb == 4'hF;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    chk_zero_wait: assert property (s_setup ##1 s_access |-> pready)
        else $error("access cycle without ready");
    chk_ready_once: assert property (pready |-> s_access ##1 !pready)
        else $error("ready outside a single access cycle");
    chk_unmapped_err: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped offset not refused");
    chk_ro_write: assert property (pready && pwrite && ofs == `SSIE_SEC_STATUS_OFS |-> pslverr)
        else $error("write to read-only status not refused");
    chk_good_noerr: assert property (pready && mapped && !(pwrite && ofs == `SSIE_SEC_STATUS_OFS) |-> !pslverr)
        else $error("error on a legal access");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready cycle");
    chk_reserved_zero: assert property (pready && !pwrite && ofs == `SSIE_SEC_STATUS_OFS |->
        prdata[31:13] == 19'h0 && !prdata[6])
        else $error("reserved status bits not zero");
    chk_enable_off: assert property (en_wr && pwdata == 32'h0 |-> ##2 !host_irq)
        else $error("interrupt with all enables off");
    chk_irq_set: assert property (en_wr && pwdata == 32'hFFFFFFFF && irq_source != 32'h0 |-> ##2 host_irq)
        else $error("enabled source raised no interrupt");
endmodule : ssie_chk

bind ssie_top ssie_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_source(irq_source), .host_irq(host_irq));

// ### dv/tb_ssie_top.sv
// Self-checking bench of the status and interrupt enable block.
`timescale 1ns/1ps
`include "ssie_regs.svh"
module tb_ssie_top;
    localparam logic [11:0] EN = `SSIE_IRQ_ENABLE_OFS;
    localparam logic [11:0] ST = `SSIE_IRQ_STATUS_OFS;
    localparam logic [11:0] SEC = `SSIE_SEC_STATUS_OFS;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, vgate = 0, lgate = 0;
    logic [31:0] paddr = 0, pwdata = 0, irq_source = 0, en_m, prdata;
    logic [3:0]  pstrb = 0;
    logic        pready, pslverr, host_irq;
    logic [9:0]  ev = 0;
    logic [4:0]  cl = 0;
    logic [32:0] exp_q[$];
    int          err_count = 0, tests_run = 0, seed = 83752;
    int          sec_pos[10] = '{12, 11, 10, 9, 8, 7, 3, 2, 1, 0};
    int          isr_pos[10] = '{9, 9, 11, 11, 11, 11, 2, 2, 2, 2};

    ssie_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_source(irq_source), .video_fifo_two_err(ev[0]), .video_fifo_one_ovf(ev[1]),
        .audio_in_fifo_two_udf(ev[2]), .audio_out_fifo_two_ovf(ev[3]), .audio_in_fifo_one_udf(ev[4]),
        .audio_out_fifo_one_ovf(ev[5]), .video_base_reload(cl[0]), .audio_in_two_restart(cl[1]),
        .audio_out_two_restart(cl[2]), .audio_in_one_restart(cl[3]), .audio_out_one_restart(cl[4]),
        .vertical_gate_mon(vgate), .line_qualifier_mon(lgate), .counter_five_flag(ev[6]),
        .counter_four_flag(ev[7]), .counter_two_flag(ev[8]), .counter_one_flag(ev[9]), .host_irq(host_irq));

    initial forever #2 pclk = ~pclk;

    task cmp(string what, logic [32:0] e, logic [32:0] s);
        tests_run++;
        if (e !== s) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask : cmp

    // One APB transfer; the expected {pslverr, prdata} is queued for the monitor.
    task apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s, logic [32:0] e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {20'h0, a};
        pwdata <= d;
        pstrb <= s;
        exp_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
            cmp("apb answer", exp_q.pop_front(), {pslverr, prdata});
    end

    // One-cycle pulse on a source, flag or clear strobe; returns when the interrupt has settled.
    task strobe(int kind, int k);
        @(posedge pclk);
        if (kind == 0) irq_source[k] <= 1'b1;
        else if (kind == 1) ev[k] <= 1'b1;
        else cl[k] <= 1'b1;
        @(posedge pclk);
        irq_source <= 0;
        ev <= 0;
        cl <= 0;
        @(posedge pclk);
        @(negedge pclk);
    endtask : strobe

    task end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    initial begin
        #100000;
        err_count++;
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, EN, 0, 4'hF, 0);
        apb(0, ST, 0, 4'hF, 0);
        apb(0, SEC, 0, 4'hF, 0);
        apb(0, 12'h100, 0, 4'hF, {1'b1, 32'h0});
        apb(1, SEC, '1, 4'hF, {1'b1, 32'h0});
        apb(0, SEC, 0, 4'hF, 0);
        $display("test map and reset done");
        en_m = $random(seed);
        apb(1, EN, en_m, 4'hF, 0);
        apb(1, EN, ~en_m, 4'h5, 0);
        en_m = {en_m[31:24], ~en_m[23:16], en_m[15:8], ~en_m[7:0]};
        apb(0, EN, 0, 4'hF, {1'b0, en_m});
        for (int i = 0; i < 32; i++) begin
            strobe(0, i);
            cmp("host_irq", en_m[i], host_irq);
            apb(0, ST, 0, 4'hF, {1'b0, 32'h1 << i});
            apb(1, ST, 32'h1 << i, 4'hF, 0);
            apb(0, ST, 0, 4'hF, 0);
        end
        $display("test interrupt sources done");
        for (int k = 0; k < 10; k++) begin
            strobe(1, k);
            apb(0, SEC, 0, 4'hF, {1'b0, 32'h1 << sec_pos[k]});
            apb(0, ST, 0, 4'hF, {1'b0, 32'h1 << isr_pos[k]});
            strobe(2, (k >= 2 && k < 6) ? k - 1 : 0);
            apb(0, SEC, 0, 4'hF, k < 6 ? 33'h0 : {1'b0, 32'h1 << sec_pos[k]});
            if (k < 6) strobe(1, k);
            apb(1, ST, 32'h1 << isr_pos[k], 4'hF, 0);
            apb(0, SEC, 0, 4'hF, 0);
            apb(0, ST, 0, 4'hF, 0);
        end
        $display("test secondary flags done");
        for (int g = 0; g < 4; g++) begin
            @(posedge pclk);
            vgate <= g[0];
            lgate <= g[1];
            repeat (4) @(posedge pclk);
            apb(0, SEC, 0, 4'hF, {1'b0, 26'h0, g[0], g[1], 4'h0});
        end
        $display("test scaler gates done");
        @(posedge pclk);
        irq_source <= $random(seed) | 1;
        apb(1, EN, '1, 4'hF, 0);
        irq_source <= 0;
        @(posedge pclk);
        @(negedge pclk);
        cmp("host_irq", 1, host_irq);
        apb(1, EN, 0, 4'hF, 0);
        apb(1, ST, '1, 4'hF, 0);
        apb(0, ST, 0, 4'hF, 0);
        $display("test enable gating done");
        end_of_test();
    end
endmodule : tb_ssie_top
